//--- tscm_pkg.sv
// constants and carriers for the slot connection memory block
package tscm_pkg;
  // byte address width on the register bus (16-bit word index)
  localparam int          AXI_AW      = 18;
  // decoded register bus targets
  localparam logic [2:0]  KIND_DM     = 3'h0;
  localparam logic [2:0]  KIND_CTRL   = 3'h1;
  localparam logic [2:0]  KIND_STAT   = 3'h2;
  localparam logic [2:0]  KIND_CM     = 3'h3;
  localparam logic [2:0]  KIND_BAD    = 3'h4;
  // word index regions, selected by index bits 15:14
  localparam logic [1:0]  RGN_DM      = 2'h0;
  localparam logic [1:0]  RGN_CTL     = 2'h1;
  localparam logic [1:0]  RGN_CM      = 2'h2;
  // control and status word indexes
  localparam logic [15:0] IDX_CTRL    = 16'h4000;
  localparam logic [15:0] IDX_STAT    = 16'h4001;
  // control reset value: bit 0 enables switching
  localparam logic [15:0] CTRL_RST    = 16'h0001;
  localparam int          CTRL_EN_BIT = 0;
  // switching modes held in connection word bits 15:14
  localparam logic [1:0]  MODE_VAR    = 2'h0;
  localparam logic [1:0]  MODE_CONST  = 2'h1;
  localparam logic [1:0]  MODE_CPU    = 2'h2;
  localparam logic [1:0]  MODE_HIGH   = 2'h3;
  localparam logic [7:0]  IDLE_BYTE   = 8'hff;
  // bus responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam int          FIFO_DEPTH  = 2;

  // one time slot of one stream
  typedef struct packed {
    logic [5:0] stream;
    logic [7:0] slot;
  } tscm_slot_s;
  // connection word: mode, source stream, source channel
  typedef struct packed {
    logic [1:0] mode;
    tscm_slot_s src;
  } tscm_conn_s;
  // one received byte with its frame bank
  typedef struct packed {
    logic       bank;
    tscm_slot_s where;
    logic [7:0] data;
  } tscm_rx_s;
  // one switched byte for an outgoing slot
  typedef struct packed {
    tscm_slot_s dest;
    logic [7:0] data;
  } tscm_tx_s;
  // switching engine states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LOOK  = 2'b01,
    ST_FETCH = 2'b10,
    ST_PUSH  = 2'b11
  } tscm_state_e;
endpackage

//--- tscm_core.sv
// slot connection memory, data memory, switching engine and register slave
//
// Overview of operation
// - every received byte is buffered in data memory; software may read any slot of the bank now being received
// - software writes to data memory are answered but change nothing
// - software can read and write every connection memory word
// - mode 10 sends the low byte software wrote onto the outgoing slot
// - switching modes route any input slot to any output slot
// - connection memory is reached only when word index bits 15:14 are 10
// - index bits 13:8 pick outgoing stream, bits 7:0 outgoing slot
// - connection memory words are sixteen bits, their indexes fourteen bits
// - word bits 15:14 mode, 13:8 source stream, 7:0 source channel
// - mode 01 switches with constant delay from the previous frame bank
// - one write of the origin word makes the connection
`timescale 1ns/100ps
`default_nettype none
module tscm_core (
  // clock and reset
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // register bus write channels
  input  wire logic [tscm_pkg::AXI_AW-1:0] s_awaddr,
  input  wire logic                       s_awvalid,
  output logic                            s_awready,
  input  wire logic [31:0]                s_wdata,
  input  wire logic [3:0]                 s_wstrb,
  input  wire logic                       s_wvalid,
  output logic                            s_wready,
  output logic [1:0]                      s_bresp,
  output logic                            s_bvalid,
  input  wire logic                       s_bready,
  // register bus read channels
  input  wire logic [tscm_pkg::AXI_AW-1:0] s_araddr,
  input  wire logic                       s_arvalid,
  output logic                            s_arready,
  output logic [31:0]                     s_rdata,
  output logic [1:0]                      s_rresp,
  output logic                            s_rvalid,
  input  wire logic                       s_rready,
  // received serial bytes
  input  wire logic                       rx_valid,
  input  wire tscm_pkg::tscm_rx_s         rx_in,
  // outgoing slot requests
  input  wire logic                       tx_req_valid,
  output logic                            tx_req_ready,
  input  wire tscm_pkg::tscm_slot_s       tx_req_dest,
  // switched bytes out
  output logic                            tx_valid,
  input  wire logic                       tx_ready,
  output tscm_pkg::tscm_tx_s              tx_out
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode shared by read and write
  function automatic logic [2:0] decode(input logic [tscm_pkg::AXI_AW-1:0] a);
    logic [15:0] idx;
    idx = a[tscm_pkg::AXI_AW-1:2];
    if (idx[15:14] == tscm_pkg::RGN_CM) begin
      decode = tscm_pkg::KIND_CM;
    end else if (idx[15:14] == tscm_pkg::RGN_DM) begin
      decode = tscm_pkg::KIND_DM;
    end else if (idx == tscm_pkg::IDX_CTRL) begin
      decode = tscm_pkg::KIND_CTRL;
    end else if (idx == tscm_pkg::IDX_STAT) begin
      decode = tscm_pkg::KIND_STAT;
    end else begin
      decode = tscm_pkg::KIND_BAD;
    end
  endfunction

  // memories: 16K connection words, two frame banks of 16K bytes
  logic [15:0]              cm_mem [0:16383];
  logic [7:0]               dm_mem [0:32767];
  logic [15:0]              ctrl;
  logic                     bank_now;
  // write side holding registers
  logic                     aw_held;
  logic                     w_held;
  logic [tscm_pkg::AXI_AW-1:0] aw_q;
  logic [15:0]              wd_q;
  logic [1:0]               ws_q;
  logic                     wr_go;
  logic [2:0]               wr_kind;
  logic [13:0]              wr_idx;
  logic [15:0]              next_cm;
  // engine
  tscm_pkg::tscm_state_e    state;
  tscm_pkg::tscm_slot_s     dest_q;
  tscm_pkg::tscm_conn_s     conn;
  logic [7:0]               fill_byte;
  logic                     fetch_bank;
  // two-entry output buffer
  tscm_pkg::tscm_tx_s       fifo [0:tscm_pkg::FIFO_DEPTH-1];
  logic                     wptr;
  logic                     rptr;
  logic [1:0]               count;
  logic                     push;
  logic                     pop;
  logic                     fifo_in_ready;

  ////////////////////////////////////////////////////////////////////////////
  // write address and data taken in either order
  assign s_awready = !aw_held && !s_bvalid;
  assign s_wready  = !w_held && !s_bvalid;
  assign wr_go     = aw_held && w_held && !s_bvalid;
  assign wr_kind   = decode(aw_q);
  assign wr_idx    = aw_q[15:2];

  // hold flags for the two write channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
    end else if (wr_go) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
    end else begin
      if (s_awvalid && s_awready) aw_held <= 1'b1;
      if (s_wvalid && s_wready) w_held <= 1'b1;
    end
  end

  // captured write payload
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= '0;
      wd_q <= 16'h0000;
      ws_q <= 2'h0;
    end else begin
      if (s_awvalid && s_awready) aw_q <= s_awaddr;
      if (s_wvalid && s_wready) begin
        wd_q <= s_wdata[15:0];
        ws_q <= s_wstrb[1:0];
      end
    end
  end

  // write response, error on unmapped word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_bvalid <= 1'b0;
      s_bresp  <= tscm_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_bvalid <= 1'b1;
      s_bresp  <= (wr_kind == tscm_pkg::KIND_BAD) ? tscm_pkg::RESP_SLVERR : tscm_pkg::RESP_OKAY;
    end else if (s_bready) begin
      s_bvalid <= 1'b0;
    end
  end

  // byte-lane merge into the old connection word
  always_comb begin
    next_cm = cm_mem[wr_idx];
    if (ws_q[0]) next_cm[7:0] = wd_q[7:0];
    if (ws_q[1]) next_cm[15:8] = wd_q[15:8];
  end

  // connection memory written only by software; one write sets a route
  always_ff @(posedge aclk) begin
    if (wr_go && wr_kind == tscm_pkg::KIND_CM) begin
      cm_mem[wr_idx] <= next_cm;
    end
  end

  // control word; data memory writes fall through untouched
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= tscm_pkg::CTRL_RST;
    end else if (wr_go && wr_kind == tscm_pkg::KIND_CTRL) begin
      if (ws_q[0]) ctrl[7:0] <= wd_q[7:0];
      if (ws_q[1]) ctrl[15:8] <= wd_q[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data memory filled only by received traffic
  always_ff @(posedge aclk) begin
    if (rx_valid) begin
      dm_mem[{rx_in.bank, rx_in.where}] <= rx_in.data;
    end
  end

  // bank of the frame now being received
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bank_now <= 1'b0;
    end else if (rx_valid) begin
      bank_now <= rx_in.bank;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel, answer one cycle after the address
  assign s_arready = !s_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
    end else if (s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

  // read data select
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rdata <= 32'h0000_0000;
      s_rresp <= tscm_pkg::RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_rresp <= tscm_pkg::RESP_OKAY;
      s_rdata <= 32'h0000_0000;
      case (decode(s_araddr))
        tscm_pkg::KIND_CM:   s_rdata[15:0] <= cm_mem[s_araddr[15:2]];
        tscm_pkg::KIND_DM:   s_rdata[7:0]  <= dm_mem[{bank_now, s_araddr[15:2]}];
        tscm_pkg::KIND_CTRL: s_rdata[15:0] <= ctrl;
        tscm_pkg::KIND_STAT: s_rdata[3:0]  <= {count, push, bank_now};
        default:             s_rresp       <= tscm_pkg::RESP_SLVERR;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // switching engine: look up route, fetch byte, push to buffer
  assign tx_req_ready = (state == tscm_pkg::ST_IDLE);
  assign push         = (state == tscm_pkg::ST_PUSH);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= tscm_pkg::ST_IDLE;
    end else begin
      case (state)
        tscm_pkg::ST_IDLE:  if (tx_req_valid) state <= tscm_pkg::ST_LOOK;
        tscm_pkg::ST_LOOK:  state <= tscm_pkg::ST_FETCH;
        tscm_pkg::ST_FETCH: state <= tscm_pkg::ST_PUSH;
        tscm_pkg::ST_PUSH:  if (fifo_in_ready) state <= tscm_pkg::ST_IDLE;
        default:            state <= tscm_pkg::ST_IDLE;
      endcase
    end
  end

  // destination capture and connection lookup
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dest_q <= '0;
      conn   <= '0;
    end else if (state == tscm_pkg::ST_IDLE && tx_req_valid) begin
      dest_q <= tx_req_dest;
    end else if (state == tscm_pkg::ST_LOOK) begin
      conn <= tscm_pkg::tscm_conn_s'(cm_mem[dest_q]);
    end
  end

  // constant delay reads the finished bank, variable the live one
  assign fetch_bank = (conn.mode == tscm_pkg::MODE_CONST) ? !bank_now : bank_now;

  // byte selection by switching mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fill_byte <= tscm_pkg::IDLE_BYTE;
    end else if (state == tscm_pkg::ST_FETCH) begin
      if (!ctrl[tscm_pkg::CTRL_EN_BIT]) begin
        fill_byte <= tscm_pkg::IDLE_BYTE;
      end else if (conn.mode == tscm_pkg::MODE_CPU) begin
        fill_byte <= conn.src.slot;
      end else if (conn.mode == tscm_pkg::MODE_HIGH) begin
        fill_byte <= tscm_pkg::IDLE_BYTE;
      end else begin
        fill_byte <= dm_mem[{fetch_bank, conn.src}];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // two-entry output buffer
  assign fifo_in_ready = (count != 2'h2);
  assign tx_valid      = (count != 2'h0);
  assign pop           = tx_valid && tx_ready;
  assign tx_out        = fifo[rptr];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wptr  <= 1'b0;
      rptr  <= 1'b0;
      count <= 2'h0;
    end else begin
      if (push && fifo_in_ready) wptr <= !wptr;
      if (pop) rptr <= !rptr;
      count <= count + 2'((push && fifo_in_ready) ? 1 : 0) - 2'(pop ? 1 : 0);
    end
  end

  // buffer storage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fifo[0] <= '0;
      fifo[1] <= '0;
    end else if (push && fifo_in_ready) begin
      fifo[wptr] <= '{dest: dest_q, data: fill_byte};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [13:0] lw_idx;
  logic [15:0] lw_dat;
  logic        lw_ok;
  logic [15:0] ar_q;
  // last connection write after byte-lane merge, for read-back checks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lw_ok  <= 1'b0;
      lw_idx <= 14'h0000;
      lw_dat <= 16'h0000;
      ar_q   <= 16'h0000;
    end else begin
      if (s_arvalid && s_arready) ar_q <= s_araddr[17:2];
      if (wr_go && wr_kind == tscm_pkg::KIND_CM) begin
        lw_ok  <= 1'b1;
        lw_idx <= wr_idx;
        lw_dat <= next_cm;
      end
    end
  end

  AST_RD_ANSWER: assert property (s_arvalid && s_arready |=> s_rvalid)
    else $error("read not answered next cycle");
  AST_DM_WR_OKAY: assert property (wr_go && wr_kind == tscm_pkg::KIND_DM |=>
    s_bvalid && s_bresp == tscm_pkg::RESP_OKAY && $stable(ctrl))
    else $error("data memory write mishandled");
  AST_CM_READBACK: assert property (s_rvalid && ar_q[15:14] == tscm_pkg::RGN_CM && lw_ok
    && ar_q[13:0] == lw_idx |-> s_rdata[15:0] == lw_dat)
    else $error("connection word read back wrong");
  AST_CPU_MODE: assert property (state == tscm_pkg::ST_FETCH && ctrl[tscm_pkg::CTRL_EN_BIT]
    && conn.mode == tscm_pkg::MODE_CPU |=> fill_byte == $past(conn.src.slot))
    else $error("processor mode byte wrong");
  AST_ROUTE: assert property (state == tscm_pkg::ST_FETCH && ctrl[tscm_pkg::CTRL_EN_BIT]
    && conn.mode == tscm_pkg::MODE_VAR |=> fill_byte == dm_mem[$past({bank_now, conn.src})])
    else $error("variable route byte wrong");
  AST_DECODE_CM: assert property (wr_go && aw_q[17:16] == tscm_pkg::RGN_CM && ws_q == 2'h3
    |=> cm_mem[$past(wr_idx)] == $past(wd_q))
    else $error("connection region write not stored");
  AST_LOOKUP: assert property (state == tscm_pkg::ST_LOOK |=>
    conn == cm_mem[{$past(dest_q.stream), $past(dest_q.slot)}])
    else $error("connection lookup wrong");
  AST_CONST_BANK: assert property (state == tscm_pkg::ST_FETCH && ctrl[tscm_pkg::CTRL_EN_BIT]
    && conn.mode == tscm_pkg::MODE_CONST |=> fill_byte == dm_mem[$past({~bank_now, conn.src})])
    else $error("constant delay read live bank");
  AST_ONE_WRITE: assert property (wr_go && wr_kind == tscm_pkg::KIND_CM && ws_q == 2'h3 |=>
    cm_mem[$past(wr_idx)] == $past(wd_q))
    else $error("single write did not set route");
  AST_REQ_TO_OUT: assert property (tx_req_valid && tx_req_ready && count == 2'h0
    |-> ##3 push ##1 tx_valid)
    else $error("switched byte late");

  CVR_CM_WRITE: cover property (wr_go && wr_kind == tscm_pkg::KIND_CM);
  CVR_CONST: cover property (push && conn.mode == tscm_pkg::MODE_CONST);
  CVR_FULL: cover property (count == 2'h2 && push);
  CVR_DM_READ: cover property (s_rvalid && ar_q[15:14] == tscm_pkg::RGN_DM);

endmodule
`default_nettype wire

//--- tscm_far_model.sv
// serial side model: received bytes in, switched bytes collected
`timescale 1ns/100ps
`default_nettype none
module tscm_far_model (
  // clock
  input  wire logic               aclk,
  // received bytes
  output logic                    rx_valid,
  output tscm_pkg::tscm_rx_s      rx_in,
  // switched bytes
  input  wire logic               tx_valid,
  output logic                    tx_ready,
  input  wire tscm_pkg::tscm_tx_s tx_out
);
  tscm_pkg::tscm_tx_s got[$];
  logic               stall;

  ////////////////////////////////////////////////////////////
  // idle at time zero, sink ready unless stalled
  initial begin
    rx_valid = 1'b0;
    rx_in    = '0;
    stall    = 1'b0;
  end
  assign tx_ready = !stall;

  // collect every byte taken
  always @(posedge aclk) begin
    if (tx_valid && tx_ready) begin
      got.push_back(tx_out);
    end
  end

  // one byte of one slot, then scrambled idle lines
  task automatic send(input logic b, input logic [5:0] s, input logic [7:0] sl, input logic [7:0] d);
    @(posedge aclk);
    rx_valid <= 1'b1;
    rx_in    <= {b, s, sl, d};
    @(posedge aclk);
    rx_valid <= 1'b0;
    rx_in    <= ~{b, s, sl, d};
  endtask
endmodule
`default_nettype wire

//--- tscm_core_bench.sv
// testbench for the slot connection memory block
`timescale 1ns/100ps
`default_nettype none
module tscm_core_bench;
  logic                        aclk;
  logic                        aresetn;
  logic [tscm_pkg::AXI_AW-1:0] s_awaddr;
  logic                        s_awvalid;
  logic                        s_awready;
  logic [31:0]                 s_wdata;
  logic [3:0]                  s_wstrb;
  logic                        s_wvalid;
  logic                        s_wready;
  logic [1:0]                  s_bresp;
  logic                        s_bvalid;
  logic                        s_bready;
  logic [tscm_pkg::AXI_AW-1:0] s_araddr;
  logic                        s_arvalid;
  logic                        s_arready;
  logic [31:0]                 s_rdata;
  logic [1:0]                  s_rresp;
  logic                        s_rvalid;
  logic                        s_rready;
  logic                        rx_valid;
  tscm_pkg::tscm_rx_s          rx_in;
  logic                        tx_req_valid;
  logic                        tx_req_ready;
  tscm_pkg::tscm_slot_s        tx_req_dest;
  logic                        tx_valid;
  logic                        tx_ready;
  tscm_pkg::tscm_tx_s          tx_out;
  int                          failures;
  int                          compares;
  int                          cycles;
  logic [31:0]                 d;
  logic [1:0]                  r;

  tscm_core tscm_core_inst (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .rx_valid(rx_valid), .rx_in(rx_in), .tx_req_valid(tx_req_valid), .tx_req_ready(tx_req_ready),
    .tx_req_dest(tx_req_dest), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_out(tx_out));
  tscm_far_model tscm_far_model_inst (.aclk(aclk), .rx_valid(rx_valid), .rx_in(rx_in), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_out(tx_out));

  ////////////////////////////////////////////////////////////
  // compares and closing report
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: response %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  // bus master: both write channels offered together
  task automatic wr(input logic [15:0] idx, input logic [15:0] v, input logic [1:0] er);
    @(posedge aclk);
    s_awaddr  <= {idx, 2'h0};
    s_awvalid <= 1'b1;
    s_wdata   <= {16'h0, v};
    s_wvalid  <= 1'b1;
    s_bready  <= 1'b1;
    fork
      begin
        @(posedge aclk iff s_awready);
        s_awvalid <= 1'b0;
      end
      begin
        @(posedge aclk iff s_wready);
        s_wvalid <= 1'b0;
      end
    join
    @(posedge aclk iff s_bvalid);
    chk_resp(s_bresp, er);
    s_bready <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] idx);
    @(posedge aclk);
    s_araddr  <= {idx, 2'h0};
    s_arvalid <= 1'b1;
    s_rready  <= 1'b1;
    @(posedge aclk iff s_arready);
    s_arvalid <= 1'b0;
    @(posedge aclk iff s_rvalid);
    d = s_rdata;
    r = s_rresp;
    s_rready <= 1'b0;
  endtask
  task automatic rd_chk(input logic [15:0] idx, input logic [15:0] v);
    rd(idx);
    chk_resp(r, tscm_pkg::RESP_OKAY);
    chk_word(d, {16'h0, v});
  endtask

  // slot requests and switched byte checks
  task automatic req(input logic [5:0] s, input logic [7:0] sl);
    @(posedge aclk);
    tx_req_valid <= 1'b1;
    tx_req_dest  <= {s, sl};
    @(posedge aclk iff tx_req_ready);
    tx_req_valid <= 1'b0;
    tx_req_dest  <= ~{s, sl};
  endtask
  task automatic pop_chk(input logic [5:0] s, input logic [7:0] sl, input logic [7:0] v);
    while (tscm_far_model_inst.got.size() == 0) begin
      @(posedge aclk);
    end
    chk_word({10'h0, tscm_far_model_inst.got.pop_front()}, {10'h0, s, sl, v});
  endtask
  // one write of the origin word, then switch that slot
  task automatic conn(input logic [5:0] s, input logic [7:0] sl, input logic [15:0] w, input logic [7:0] v);
    wr({2'b10, s, sl}, w, tscm_pkg::RESP_OKAY);
    req(s, sl);
    pop_chk(s, sl, v);
  endtask

  ////////////////////////////////////////////////////////////
  // clock, time-zero inputs, timeout
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  initial begin
    {aresetn, s_awaddr, s_awvalid, s_wdata, s_wvalid, s_bready} = '0;
    {s_araddr, s_arvalid, s_rready, tx_req_valid, tx_req_dest} = '0;
    {failures, compares, cycles} = '0;
    s_wstrb = 4'hf;
  end
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      failures++;
      give_verdict;
    end
  end

  // main sequence
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(tscm_pkg::IDX_CTRL, tscm_pkg::CTRL_RST);
    tscm_far_model_inst.send(1'b0, 6'd4, 8'd0, 8'h5a);
    tscm_far_model_inst.send(1'b1, 6'd4, 8'd0, 8'ha5);
    tscm_far_model_inst.send(1'b1, 6'd7, 8'd200, 8'h3c);
    rd_chk({2'b00, 6'd4, 8'd0}, 16'h00a5);
    wr({2'b00, 6'd4, 8'd0}, 16'h0033, tscm_pkg::RESP_OKAY);
    rd_chk({2'b00, 6'd4, 8'd0}, 16'h00a5);
    conn(6'd13, 8'd9, {tscm_pkg::MODE_CONST, 6'd4, 8'd0}, 8'h5a);
    rd_chk({2'b10, 6'd13, 8'd9}, 16'h4400);
    conn(6'd63, 8'd255, {tscm_pkg::MODE_VAR, 6'd7, 8'd200}, 8'h3c);
    conn(6'd13, 8'd10, {tscm_pkg::MODE_VAR, 6'd4, 8'd0}, 8'ha5);
    conn(6'd1, 8'd5, {tscm_pkg::MODE_CPU, 6'd9, 8'hc3}, 8'hc3);
    conn(6'd2, 8'd3, {tscm_pkg::MODE_HIGH, 6'd4, 8'd0}, tscm_pkg::IDLE_BYTE);
    rd_chk({2'b10, 6'd1, 8'd5}, {tscm_pkg::MODE_CPU, 6'd9, 8'hc3});
    // low byte lane only: high byte of the word is kept
    s_wstrb <= 4'h1;
    wr({2'b10, 6'd2, 8'd3}, 16'h12ab, tscm_pkg::RESP_OKAY);
    s_wstrb <= 4'hf;
    rd_chk({2'b10, 6'd2, 8'd3}, 16'hc4ab);
    // same low bits outside connection memory leave it alone
    wr({2'b00, 6'd13, 8'd9}, 16'h0011, tscm_pkg::RESP_OKAY);
    rd_chk({2'b10, 6'd13, 8'd9}, 16'h4400);
    rd(16'hc000);
    chk_resp(r, tscm_pkg::RESP_SLVERR);
    wr(16'hc000, 16'h0001, tscm_pkg::RESP_SLVERR);
    // switching disabled gives idle bytes
    wr(tscm_pkg::IDX_CTRL, 16'h0000, tscm_pkg::RESP_OKAY);
    req(6'd13, 8'd9);
    pop_chk(6'd13, 8'd9, tscm_pkg::IDLE_BYTE);
    rd_chk(tscm_pkg::IDX_CTRL, 16'h0000);
    wr(tscm_pkg::IDX_CTRL, tscm_pkg::CTRL_RST, tscm_pkg::RESP_OKAY);
    // stalled sink: buffer fills, engine refuses, nothing lost
    tscm_far_model_inst.stall <= 1'b1;
    req(6'd13, 8'd9);
    req(6'd13, 8'd10);
    repeat (4) @(posedge aclk);
    rd(tscm_pkg::IDX_STAT);
    chk_word(d & 32'hd, 32'h9);
    fork
      req(6'd1, 8'd5);
      begin
        repeat (8) @(posedge aclk);
        @(negedge aclk);
        chk_word({31'h0, tx_req_ready}, 32'h0);
        chk_word({31'h0, tx_valid}, 32'h1);
        @(posedge aclk);
        tscm_far_model_inst.stall <= 1'b0;
      end
    join
    pop_chk(6'd13, 8'd9, 8'h5a);
    pop_chk(6'd13, 8'd10, 8'ha5);
    pop_chk(6'd1, 8'd5, 8'hc3);
    repeat (6) @(posedge aclk);
    chk_word({31'h0, tx_valid}, 32'h0);
    give_verdict;
  end
endmodule
`default_nettype wire
